// [rtl/stc_pkg.sv]
`default_nettype none
package stc_pkg;
    // register word addresses on the bus (byte addresses)
    localparam logic [7:0] STC_OFF_CONTROL   = 8'h00;
    localparam logic [7:0] STC_OFF_COUNT_LOW = 8'h04;
    localparam logic [7:0] STC_OFF_COUNT_HIGH = 8'h08;
    localparam logic [7:0] STC_OFF_FLAG      = 8'h0C;
    localparam logic [7:0] STC_OFF_ENABLE    = 8'h10;
    localparam logic [7:0] STC_OFF_COMPARE   = 8'h14;
    localparam logic [7:0] STC_OFF_STATUS    = 8'h18;
    // control register field positions, and the flag bit of the flag and enable registers
    localparam int STC_BIT_WIDE    = 7;
    localparam int STC_BIT_XTALRUN = 6;
    localparam int STC_BIT_PS_HI   = 5;
    localparam int STC_BIT_PS_LO   = 4;
    localparam int STC_BIT_OSCEN   = 3;
    localparam int STC_BIT_NOSYNC  = 2;
    localparam int STC_BIT_SRC     = 1;
    localparam int STC_BIT_RUN     = 0;
    localparam int STC_BIT_FLAG    = 0;
    // compare unit: mode code that issues the special event trigger
    localparam logic [3:0] STC_MODE_TRIGGER = 4'b1011;
    // reset values
    localparam logic [7:0] STC_CONTROL_RST = 8'h00;
    // instruction cycle = four hclk cycles
    localparam logic [1:0] STC_QUARTER_LAST = 2'h3;
    // ahb encodings
    localparam logic [1:0] STC_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] STC_HTRANS_SEQ    = 2'b11;
endpackage
`default_nettype wire

// [rtl/stc_timer.sv]
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - bit 7 selects 16-bit buffered access
// - bit 6 reads one when crystal clocks system and bit 3 is set
// - two-bit prescale 1,2,4,8
// - bit 3 runs crystal oscillator
// - bit 2 skips sync for external source
// - bit 1 picks internal or external clock
// - bit 0 runs counter, else holds
// - increment per instruction cycle or rising edge
// - oscillator on forces pins input, read zero
// - wrap FFFFh to 0000h sets flag
// - flag forwarded only when enabled
// - compare trigger in mode 1011 resets counter
// - trigger reset never sets overflow flag
// - counter write beats same-cycle trigger
// - wide low read copies high byte to buffer
// - wide high writes buffer, low write loads
// - low write clears prescaler, high not
// - oscillator keeps running in power modes
module stc_timer
    import stc_pkg::*;
(
    input  wire logic        hclk,            // system clock, 25 MHz
    input  wire logic        hresetn,         // async reset, active low
    input  wire logic        hsel,            // slave select
    input  wire logic [7:0]  haddr,           // byte address
    input  wire logic [1:0]  htrans,          // transfer type
    input  wire logic        hwrite,          // write when high
    input  wire logic [2:0]  hsize,           // transfer size
    input  wire logic        hready,          // bus ready in
    input  wire logic [31:0] hwdata,          // write data
    output logic      [31:0] hrdata,          // read data
    output logic             hreadyout,       // slave ready
    output logic             hresp,           // always okay
    input  wire logic        ext_count_pin,   // external count input
    input  wire logic        xtal_in_pin,     // crystal clock level
    input  wire logic        sysclk_on_xtal,  // system clock comes from crystal
    input  wire logic        compare_trigger, // special event trigger pulse
    input  wire logic [3:0]  compare_mode_code, // compare unit mode
    input  wire logic        power_managed,   // device in power-managed mode
    output logic             xtal_osc_run,    // oscillator amplifier on
    output logic             pin_force_input, // override pin_direction_bits
    output logic             pin_read_zero,   // port reads of the pins give zero
    output logic             overflow_irq     // interrupt request
);
    import stc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  control;
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [7:0]  high_buffer;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic [15:0] compare_value_pair;
    logic [2:0]  prescale_cnt;
    logic [1:0]  quarter_cnt;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;

    // bus write strobes in the data phase
    logic wr_ctrl, wr_low, wr_high, wr_flag, wr_en, wr_cmp;
    logic rd_low;
    assign wr_ctrl = ap_valid && ap_write && ap_addr == STC_OFF_CONTROL;
    assign wr_low  = ap_valid && ap_write && ap_addr == STC_OFF_COUNT_LOW;
    assign wr_high = ap_valid && ap_write && ap_addr == STC_OFF_COUNT_HIGH;
    assign wr_flag = ap_valid && ap_write && ap_addr == STC_OFF_FLAG;
    assign wr_en   = ap_valid && ap_write && ap_addr == STC_OFF_ENABLE;
    assign wr_cmp  = ap_valid && ap_write && ap_addr == STC_OFF_COMPARE;
    // low read taken at the address phase, the same edge that samples the low byte
    assign rd_low  = hready && hsel && htrans[1] && !hwrite && {haddr[7:2], 2'b00} == STC_OFF_COUNT_LOW;

    logic wide;
    logic osc_on;
    logic ext_src;
    assign wide    = control[STC_BIT_WIDE];
    assign osc_on  = control[STC_BIT_OSCEN];
    assign ext_src = control[STC_BIT_SRC];

    ////////////////////////////////////////////////////////////////////////
    // address phase capture, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end
        else if (hready)
        begin
            ap_valid <= hsel && (htrans == STC_HTRANS_NONSEQ || htrans == STC_HTRANS_SEQ);
            ap_write <= hwrite;
            ap_addr  <= {haddr[7:2], 2'b00};
        end
    end

    // answer every transfer at once with okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data mux registered at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && !hwrite && htrans[1])
        begin
            case ({haddr[7:2], 2'b00})
                STC_OFF_CONTROL:    hrdata <= {24'h00_0000, control[7],
                                              sysclk_on_xtal && osc_on, control[5:0]};
                STC_OFF_COUNT_LOW:  hrdata <= {24'h00_0000, count_low_byte};
                STC_OFF_COUNT_HIGH: hrdata <= {24'h00_0000,
                                              wide ? high_buffer : count_high_byte};
                STC_OFF_FLAG:       hrdata <= {24'h00_0000, 7'h00, overflow_flag};
                STC_OFF_ENABLE:     hrdata <= {24'h00_0000, 7'h00, overflow_irq_enable};
                STC_OFF_COMPARE:    hrdata <= {16'h0000, compare_value_pair};
                STC_OFF_STATUS:     hrdata <= {28'h000_0000, compare_mode_code};
                default:            hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register, bit 6 is not stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            control <= STC_CONTROL_RST;
        else if (wr_ctrl)
            control <= {hwdata[7], 1'b0, hwdata[5:0]};
    end

    // interrupt enable and compare pair
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            overflow_irq_enable <= 1'b0;
            compare_value_pair  <= 16'h0000;
        end
        else
        begin
            if (wr_en)
                overflow_irq_enable <= hwdata[STC_BIT_FLAG];
            if (wr_cmp)
                compare_value_pair <= hwdata[15:0];
        end
    end

    // oscillator control and pin override
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xtal_osc_run    <= 1'b0;
            pin_force_input <= 1'b0;
            pin_read_zero   <= 1'b0;
        end
        else
        begin
            xtal_osc_run    <= osc_on || (osc_on && power_managed);
            pin_force_input <= osc_on;
            pin_read_zero   <= osc_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external source: crystal when enabled, else the count pin
    logic ext_raw;
    logic ext_level;
    logic ext_rise;
    assign ext_raw = osc_on ? xtal_in_pin : ext_count_pin;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= ext_raw;
            ext_sync <= ext_meta;
            ext_prev <= ext_level;
        end
    end

    // unsynchronised path samples the input directly
    assign ext_level = control[STC_BIT_NOSYNC] ? ext_raw : ext_sync;
    assign ext_rise  = ext_level && !ext_prev;

    // instruction cycle divider
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            quarter_cnt <= 2'h0;
        else
            quarter_cnt <= quarter_cnt + 2'h1;
    end

    logic tick_in;
    assign tick_in = ext_src ? ext_rise : (quarter_cnt == STC_QUARTER_LAST);

    // prescale terminal count
    function automatic logic ps_done(input logic [1:0] sel, input logic [2:0] cnt);
        logic [2:0] last;
        last = 3'((4'h1 << sel) - 4'h1);
        return cnt == last;
    endfunction

    logic run;
    logic step;
    assign run  = control[STC_BIT_RUN];
    assign step = run && tick_in && ps_done(control[5:4], prescale_cnt);

    // prescaler
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prescale_cnt <= 3'h0;
        else if (wr_low)
            prescale_cnt <= 3'h0;
        else if (run && tick_in)
            prescale_cnt <= ps_done(control[5:4], prescale_cnt) ? 3'h0 : prescale_cnt + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    logic trig;
    logic wrap;
    assign trig = compare_trigger && compare_mode_code == STC_MODE_TRIGGER;
    assign wrap = step && {count_high_byte, count_low_byte} == 16'hFFFF;

    // a wide high write only fills the buffer, so the counter keeps running
    logic wr_count;
    assign wr_count = wr_low || (wr_high && !wide);

    // counter: write beats trigger, trigger beats counting
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_low_byte  <= 8'h00;
            count_high_byte <= 8'h00;
        end
        else if (wr_count)
        begin
            if (wr_low)
                count_low_byte <= hwdata[7:0];
            if (wr_low && wide)
                count_high_byte <= high_buffer;
            if (wr_high && !wide)
                count_high_byte <= hwdata[7:0];
        end
        else if (trig)
        begin
            count_low_byte  <= 8'h00;
            count_high_byte <= 8'h00;
        end
        else if (step)
            {count_high_byte, count_low_byte} <= {count_high_byte, count_low_byte} + 16'h0001;
    end

    // high byte buffer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            high_buffer <= 8'h00;
        else if (wide && rd_low)
            high_buffer <= count_high_byte;
        else if (wide && wr_high)
            high_buffer <= hwdata[7:0];
    end

    // overflow flag, set wins over clear
    logic counted;
    assign counted = wrap && !wr_count && !trig;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overflow_flag <= 1'b0;
        else if (counted)
            overflow_flag <= 1'b1;
        else if (wr_flag)
            overflow_flag <= hwdata[STC_BIT_FLAG];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overflow_irq <= 1'b0;
        else
            overflow_irq <= overflow_flag && overflow_irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_flag_on_wrap;
        @(posedge hclk) disable iff (!hresetn)
        counted |=> overflow_flag && {count_high_byte, count_low_byte} == 16'h0000;
    endproperty
    a_flag_on_wrap: assert property (p_flag_on_wrap) else $error("wrap did not set flag");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        overflow_irq |-> $past(overflow_flag) && $past(overflow_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled flag");

    property p_trig_clears;
        @(posedge hclk) disable iff (!hresetn)
        trig && !wr_low && !wr_high |=> {count_high_byte, count_low_byte} == 16'h0000;
    endproperty
    a_trig_clears: assert property (p_trig_clears) else $error("trigger did not clear");

    property p_trig_no_flag;
        @(posedge hclk) disable iff (!hresetn)
        trig && !overflow_flag && !wr_flag |=> !overflow_flag;
    endproperty
    a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger set flag");

    property p_write_wins;
        @(posedge hclk) disable iff (!hresetn)
        wr_low && trig |=> count_low_byte == $past(hwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

    property p_hold_stopped;
        @(posedge hclk) disable iff (!hresetn)
        !run && !wr_low && !wr_high && !trig |=> $stable({count_high_byte, count_low_byte});
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("stopped counter moved");

    property p_low_read_buffers;
        @(posedge hclk) disable iff (!hresetn)
        wide && rd_low && !wr_high |=> high_buffer == $past(count_high_byte);
    endproperty
    a_low_read_buffers: assert property (p_low_read_buffers) else $error("buffer not loaded");

    property p_wide_high_write;
        @(posedge hclk) disable iff (!hresetn)
        wide && wr_high |=> count_high_byte == $past(count_high_byte) || $past(trig) || $past(step);
    endproperty
    a_wide_high_write: assert property (p_wide_high_write) else $error("high write hit counter");

    property p_prescale_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_low |=> prescale_cnt == 3'h0;
    endproperty
    a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared");

    property p_pins;
        @(posedge hclk) disable iff (!hresetn)
        osc_on [*2] |-> pin_force_input && pin_read_zero && xtal_osc_run;
    endproperty
    a_pins: assert property (p_pins) else $error("pins not forced");

    property p_internal_rate;
        @(posedge hclk) disable iff (!hresetn)
        step && !ext_src |-> quarter_cnt == STC_QUARTER_LAST;
    endproperty
    a_internal_rate: assert property (p_internal_rate) else $error("internal step off cycle");

endmodule
`default_nettype wire

// [tb/stc_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// far side of the timer: counting input, crystal level and compare unit trigger
module stc_far_model
(
    input  wire logic       hclk,     // system clock
    output logic            ext_pin,  // external counting input
    output logic            xtal_pin, // crystal level, still while unused
    output logic            trig,     // special event trigger pulse
    output logic [3:0]      mode      // compare unit mode code
);
    // idle levels at time zero
    initial
    begin
        ext_pin  = 1'b0;
        xtal_pin = 1'b0;
        trig     = 1'b0;
        mode     = 4'h0;
    end

    // n rising edges, slow against the core clock so every edge is seen
    task pulses(input int n);
        repeat (n)
        begin
            @(posedge hclk);
            ext_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_pin <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask

    // n rising edges of the crystal level, same pace as the count pin
    task xpulses(input int n);
        repeat (n)
        begin
            @(posedge hclk);
            xtal_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            xtal_pin <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask

    // one-cycle trigger after d spare cycles; bench runs prescale 1 on the synchronised path
    task fire(input logic [3:0] m, input int d);
        mode <= m;
        repeat (d + 1) @(posedge hclk);
        trig <= 1'b1;
        @(posedge hclk);
        trig <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// [tb/tb_stc_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_stc_timer;
    import stc_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp, ext, xtal, trig;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q, junk;
    logic [3:0]  mode;
    logic        sysclk_on_xtal, power_managed, osc_run, force_in, read_zero, irq;
    int          miscompares = 0;
    int          checks_done = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock and design
    always #20 hclk = ~hclk;

    stc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext), .xtal_in_pin(xtal),
        .sysclk_on_xtal(sysclk_on_xtal), .compare_trigger(trig), .compare_mode_code(mode),
        .power_managed(power_managed), .xtal_osc_run(osc_run), .pin_force_input(force_in),
        .pin_read_zero(read_zero), .overflow_irq(irq));

    stc_far_model far (.hclk(hclk), .ext_pin(ext), .xtal_pin(xtal), .trig(trig), .mode(mode));

    ////////////////////////////////////////////////////////////////////////
    // compare, bus and closing tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= STC_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, junk);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        rdc(STC_OFF_CONTROL, 32'h0000_0000);
        chk(32'({osc_run, force_in, read_zero, irq, hresp, hreadyout}), 32'h0000_0001);
        rdc(8'h1C, 32'h0000_0000); // unmapped place reads zero
        $display("test reset done");
    endtask

    task t_ctrl;
        wr(STC_OFF_CONTROL, 32'h0000_0048); // status bit cannot be written
        rdc(STC_OFF_CONTROL, 32'h0000_0008);
        sysclk_on_xtal <= 1'b1;
        power_managed  <= 1'b1;
        repeat (200) @(posedge hclk); // start-up delay before relying on the crystal
        rdc(STC_OFF_CONTROL, 32'h0000_0048);
        chk(32'({osc_run, force_in, read_zero}), 32'h0000_0007);
        power_managed <= 1'b0;
        wr(STC_OFF_CONTROL, 32'h0000_000b);
        wr(STC_OFF_COUNT_LOW, 32'h0000_0000);
        far.pulses(2);
        far.xpulses(3);
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0003);
        chk(32'(osc_run), 32'h0000_0001);
        wr(STC_OFF_CONTROL, 32'h0000_0000);
        sysclk_on_xtal <= 1'b0;
        power_managed  <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'({osc_run, force_in, read_zero}), 32'h0000_0000);
        $display("test control done");
    endtask

    task t_prescale;
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(STC_OFF_CONTROL, 32'(8'h03 | (ps << 4) | (ps == 3 ? 4 : 0)));
            wr(STC_OFF_COUNT_HIGH, 32'h0000_0000);
            wr(STC_OFF_COUNT_LOW, 32'h0000_0000);
            far.pulses(16);
            rdc(STC_OFF_COUNT_LOW, 32'(16 >> ps));
        end
        wr(STC_OFF_CONTROL, 32'h0000_0002);
        far.pulses(4);
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0002);
        wr(STC_OFF_CONTROL, 32'h0000_0013);
        wr(STC_OFF_COUNT_LOW, 32'h0000_0000);
        far.pulses(1);
        wr(STC_OFF_COUNT_HIGH, 32'h0000_0000);
        far.pulses(1);
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0001);
        wr(STC_OFF_CONTROL, 32'h0000_0005);
        wr(STC_OFF_COUNT_LOW, 32'h0000_0000);
        repeat (400) @(posedge hclk);
        wr(STC_OFF_CONTROL, 32'h0000_0000);
        xfer(1'b0, STC_OFF_COUNT_LOW, 32'h0000_0000, q);
        chk(32'(q >= 99 && q <= 102), 32'h0000_0001);
        $display("test prescale done");
    endtask

    task t_overflow;
        wr(STC_OFF_CONTROL, 32'h0000_0003);
        wr(STC_OFF_COUNT_HIGH, 32'h0000_00ff);
        rdc(STC_OFF_COUNT_HIGH, 32'h0000_00ff);
        wr(STC_OFF_COUNT_LOW, 32'h0000_00fe);
        far.pulses(1);
        rdc(STC_OFF_FLAG, 32'h0000_0000);
        far.pulses(1);
        rdc(STC_OFF_FLAG, 32'h0000_0001);
        rdc(STC_OFF_COUNT_HIGH, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(STC_OFF_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0001);
        wr(STC_OFF_FLAG, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        $display("test overflow done");
    endtask

    task t_trigger;
        wr(STC_OFF_COUNT_HIGH, 32'h0000_0012);
        wr(STC_OFF_COUNT_LOW, 32'h0000_0000);
        far.pulses(5);
        far.fire(4'b0000, 0);
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0005);
        far.fire(STC_MODE_TRIGGER, 0);
        rdc(STC_OFF_COUNT_HIGH, 32'h0000_0000);
        rdc(STC_OFF_FLAG, 32'h0000_0000);
        fork
            wr(STC_OFF_COUNT_LOW, 32'h0000_0033);
            far.fire(STC_MODE_TRIGGER, 1);
        join
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0033);
        wr(STC_OFF_COMPARE, 32'h0000_abcd);
        rdc(STC_OFF_COMPARE, 32'h0000_abcd);
        rdc(STC_OFF_STATUS, 32'(STC_MODE_TRIGGER));
        $display("test trigger done");
    endtask

    task t_wide;
        wr(STC_OFF_CONTROL, 32'h0000_0080);
        rdc(STC_OFF_CONTROL, 32'h0000_0080);
        wr(STC_OFF_COUNT_HIGH, 32'h0000_0012);
        wr(STC_OFF_COUNT_LOW, 32'h0000_0034);
        wr(STC_OFF_COUNT_HIGH, 32'h0000_0056);
        wr(STC_OFF_CONTROL, 32'h0000_0000);
        rdc(STC_OFF_COUNT_HIGH, 32'h0000_0012);
        wr(STC_OFF_CONTROL, 32'h0000_0080);
        rdc(STC_OFF_COUNT_LOW, 32'h0000_0034);
        rdc(STC_OFF_COUNT_HIGH, 32'h0000_0012);
        $display("test wide access done");
    endtask

    task t_midreset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(STC_OFF_CONTROL, 32'h0000_0000);
        $display("test mid-run reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize          = 3'b010;
        hresetn        = 1'b0;
        sysclk_on_xtal = 1'b0;
        power_managed  = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_ctrl;
        t_prescale;
        t_overflow;
        t_trigger;
        t_wide;
        t_midreset;
        complete_run;
    end

    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
